// ### hw/lmd_pkg.sv
// Constants and register map for the LCD mode decode and register select block.
package lmd_pkg;
  localparam int DATA_W = 8;
  localparam int IDX_W = 5;
  localparam int SLOT_W = 4;
  localparam int MODE_W = 4;
  localparam int RATE_W = 6;
  localparam int NUM_SLOTS = 14;
  // Register indexes as seen through the index register.
  localparam logic [IDX_W-1:0] IDX_HTOTAL = 5'h00;
  localparam logic [IDX_W-1:0] IDX_HDISP = 5'h01;
  localparam logic [IDX_W-1:0] IDX_FIRST_MID = 5'h09;
  localparam logic [IDX_W-1:0] IDX_LAST_MID = 5'h0F;
  localparam logic [IDX_W-1:0] IDX_FIRST_HIGH = 5'h12;
  localparam logic [IDX_W-1:0] IDX_MODE = 5'h16;
  // Storage slots of the three registers the logic itself reads.
  localparam logic [SLOT_W-1:0] SLOT_HTOTAL = 4'h0;
  localparam logic [SLOT_W-1:0] SLOT_HDISP = 4'h1;
  localparam logic [SLOT_W-1:0] SLOT_MODE = 4'hD;
  localparam logic [SLOT_W-1:0] SLOT_MID_BASE = 4'h2;
  localparam logic [SLOT_W-1:0] SLOT_HIGH_BASE = 4'h9;
  localparam logic [DATA_W-1:0] REG_RESET = 8'h00;
  // Mode register bit positions.
  localparam int MBIT_ATTR = 0;
  localparam int MBIT_WIDE = 2;
  localparam int MBIT_GRAPH = 3;
  // Display mode numbers; zero marks a prohibited combination.
  localparam logic [MODE_W-1:0] MODE_NONE = 4'h0;
  localparam logic [MODE_W-1:0] MODE_1 = 4'h1;
  localparam logic [MODE_W-1:0] MODE_2 = 4'h2;
  localparam logic [MODE_W-1:0] MODE_3 = 4'h3;
  localparam logic [MODE_W-1:0] MODE_4 = 4'h4;
  localparam logic [MODE_W-1:0] MODE_5 = 4'h5;
  localparam logic [MODE_W-1:0] MODE_6 = 4'h6;
  localparam logic [MODE_W-1:0] MODE_7 = 4'h7;
  localparam logic [MODE_W-1:0] MODE_8 = 4'h8;
  localparam logic [MODE_W-1:0] MODE_9 = 4'h9;
  localparam logic [MODE_W-1:0] MODE_10 = 4'hA;
  localparam logic [MODE_W-1:0] MODE_11 = 4'hB;
  localparam logic [MODE_W-1:0] MODE_12 = 4'hC;
  localparam logic [MODE_W-1:0] MODE_13 = 4'hD;
  // Memory read rates in Mbps and the 16/m gap of the line restriction.
  localparam logic [RATE_W-1:0] RATE_NORMAL = 6'h14;
  localparam logic [RATE_W-1:0] RATE_WIDE = 6'h0A;
  localparam logic [RATE_W-1:0] RATE_LARGE = 6'h28;
  localparam logic [DATA_W:0] GAP_M1 = 9'h010;
  localparam logic [DATA_W:0] GAP_M2 = 9'h008;
  localparam logic [DATA_W:0] GAP_M4 = 9'h004;
  localparam logic [DATA_W:0] ONE_9 = 9'h001;
  // Extra panel beats that follow the first beat of a fetched byte.
  localparam logic [1:0] BEATS_ONE = 2'h1;
  localparam logic [1:0] BEATS_TWO = 2'h2;
  localparam logic [1:0] BEATS_FOUR = 2'h3;
  typedef enum logic [0:0] {LMD_IDLE, LMD_SEND} lmd_seq_e;
endpackage : lmd_pkg

// ### hw/lmd_top.sv
// Mode decode, register select and panel beat sequencer of the LCD timing controller.
`timescale 1ns/100ps
module lmd_top (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic cs_n,
  input wire logic wr_n,
  input wire logic rd_n,
  input wire logic index_data_select,
  input wire logic [lmd_pkg::DATA_W-1:0] db_in,
  output logic [lmd_pkg::DATA_W-1:0] db_out,
  output logic db_oe,
  input wire logic screen_split_sel,
  input wire logic graphic_char_sel,
  input wire logic bus_width_sel,
  input wire logic wide_sel,
  input wire logic attr_func_sel,
  input wire logic frame_start,
  input wire logic fetch_valid,
  input wire logic [lmd_pkg::DATA_W-1:0] fetch_data,
  output logic fetch_ready,
  output logic [3:0] up_data,
  output logic [3:0] down_data,
  output logic panel_strobe,
  output logic [lmd_pkg::MODE_W-1:0] mode_num,
  output logic mode_error,
  output logic dual_panel,
  output logic bus8_mode,
  output logic graphic_mode,
  output logic wide_mode,
  output logic attr_enable,
  output logic or_enable,
  output logic [lmd_pkg::RATE_W-1:0] mem_rate_mbps,
  output logic fmt_violation
);
  import lmd_pkg::*;

  logic [DATA_W-1:0] regs_reg [NUM_SLOTS];
  logic [IDX_W-1:0] index_reg;
  logic wr_seen_reg;
  logic [4:0] sel_reg;
  logic [MODE_W-1:0] mode_reg;
  logic err_reg;
  lmd_seq_e seq_reg;
  logic [1:0] beat_reg;
  logic [DATA_W-1:0] byte_reg;
  logic [3:0] up_reg;
  logic [3:0] down_reg;
  logic strobe_reg;
  logic [DATA_W-1:0] db_reg;
  logic [MODE_W-1:0] decoded;
  logic wr_edge;
  logic idx_valid;
  logic [SLOT_W-1:0] idx_slot;
  logic [1:0] beats_needed;
  logic is_char;
  logic is_wide;
  logic is_dual;
  logic is_bus8;

  // Maps a register index to its storage slot; the top bit flags a valid index.
  function automatic logic [SLOT_W:0] slot_of(input logic [IDX_W-1:0] idx);
    logic [SLOT_W:0] r;
    r = '0;
    if (idx == IDX_HTOTAL || idx == IDX_HDISP) begin
      r = {1'b1, idx[SLOT_W-1:0]};
    end else if (idx >= IDX_FIRST_MID && idx <= IDX_LAST_MID) begin
      r = {1'b1, SLOT_W'(idx - IDX_FIRST_MID) + SLOT_MID_BASE};
    end else if (idx >= IDX_FIRST_HIGH && idx <= IDX_MODE) begin
      r = {1'b1, SLOT_W'(idx - IDX_FIRST_HIGH) + SLOT_HIGH_BASE};
    end
    return r;
  endfunction : slot_of

  // Decodes {split, graphic, bus width, wide, attribute} into a mode number.
  function automatic logic [MODE_W-1:0] mode_of(input logic [4:0] s);
    logic [MODE_W-1:0] m;
    m = MODE_NONE;
    case (s)
      5'h10, 5'h11: m = MODE_1;
      5'h12, 5'h13: m = MODE_2;
      5'h19: m = MODE_3;
      5'h18: m = MODE_4;
      5'h00, 5'h01: m = MODE_5;
      5'h02, 5'h03: m = MODE_6;
      5'h09: m = MODE_7;
      5'h08: m = MODE_8;
      5'h04, 5'h05: m = MODE_9;
      5'h06, 5'h07: m = MODE_10;
      5'h0D: m = MODE_11;
      5'h0C: m = MODE_12;
      5'h1D: m = MODE_13;
      default: m = MODE_NONE;
    endcase
    return m;
  endfunction : mode_of

  // Index decode and a single write per strobe low phase.
  assign {idx_valid, idx_slot} = slot_of(index_reg);
  assign wr_edge = !cs_n && !wr_n && !wr_seen_reg;

  // Strobe tracker so a long write strobe acts once.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wr_seen_reg <= 1'b0;
    end else begin
      wr_seen_reg <= !cs_n && !wr_n;
    end
  end

  // Index register loads when the select line is low.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      index_reg <= '0;
    end else if (wr_edge && !index_data_select) begin
      index_reg <= db_in[IDX_W-1:0];
    end
  end

  // Data registers; an invalid index leaves every register untouched.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < NUM_SLOTS; i++) begin
        regs_reg[i] <= REG_RESET;
      end
    end else if (wr_edge && index_data_select && idx_valid) begin
      regs_reg[idx_slot] <= db_in;
    end
  end

  // Read data comes from a flip-flop; invalid reads return zero.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      db_reg <= '0;
    end else if (!cs_n && !rd_n) begin
      if (!index_data_select) begin
        db_reg <= DATA_W'(index_reg);
      end else if (idx_valid) begin
        db_reg <= regs_reg[idx_slot];
      end else begin
        db_reg <= '0;
      end
    end
  end
  assign db_out = db_reg;
  assign db_oe = !cs_n && !rd_n;

  // Samples the pins, each ORed with its mode register bit where one exists.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sel_reg <= '0;
    end else begin
      sel_reg <= {screen_split_sel,
                  graphic_char_sel | regs_reg[SLOT_MODE][MBIT_GRAPH],
                  bus_width_sel,
                  wide_sel | regs_reg[SLOT_MODE][MBIT_WIDE],
                  attr_func_sel | regs_reg[SLOT_MODE][MBIT_ATTR]};
    end
  end
  assign decoded = mode_of(sel_reg);

  // Mode changes only at a frame boundary; a prohibited set keeps the old mode.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      mode_reg <= MODE_5;
      err_reg <= 1'b0;
    end else if (frame_start) begin
      err_reg <= (decoded == MODE_NONE);
      if (decoded != MODE_NONE) begin
        mode_reg <= decoded;
      end
    end
  end

  // Mode properties derived from the applied mode number and, for attr_enable and or_enable, also from sel_reg[0].
  assign is_dual = mode_reg inside {MODE_1, MODE_2, MODE_3, MODE_4, MODE_13};
  assign is_bus8 = mode_reg inside {MODE_9, MODE_10, MODE_11, MODE_12};
  assign is_char = mode_reg inside {MODE_1, MODE_2, MODE_5, MODE_6, MODE_9, MODE_10};
  assign is_wide = mode_reg inside {MODE_2, MODE_6, MODE_10};
  assign mode_num = mode_reg;
  assign mode_error = err_reg;
  assign dual_panel = is_dual;
  assign bus8_mode = is_bus8;
  assign graphic_mode = !is_char;
  assign wide_mode = is_wide;
  assign attr_enable = is_char && sel_reg[0];
  assign or_enable = is_char && !sel_reg[0];

  // Memory read rate per mode.
  always_comb begin
    if (mode_reg == MODE_13) begin
      mem_rate_mbps = RATE_LARGE;
    end else if (is_wide) begin
      mem_rate_mbps = RATE_WIDE;
    end else begin
      mem_rate_mbps = RATE_NORMAL;
    end
  end

  // Flags a line format that breaks displayed plus 16/m within total plus one.
  always_comb begin
    logic [DATA_W:0] gap;
    gap = GAP_M2;
    if (mode_reg == MODE_5 || mode_reg == MODE_9) begin
      gap = GAP_M1;
    end else if (mode_reg inside {MODE_2, MODE_3, MODE_4}) begin
      gap = GAP_M4;
    end
    fmt_violation = ({1'b0, regs_reg[SLOT_HDISP]} + gap) >
                    ({1'b0, regs_reg[SLOT_HTOTAL]} + ONE_9);
  end

  // Beats per fetched byte: single 4-bit needs two nibbles, wide doubles it.
  always_comb begin
    if (!is_dual && !is_bus8) begin
      beats_needed = is_wide ? BEATS_FOUR : BEATS_ONE;
    end else begin
      beats_needed = is_wide ? BEATS_ONE : '0;
    end
  end
  assign fetch_ready = (seq_reg == LMD_IDLE);

  // Panel sequencer: accepts a byte, then emits the remaining beats.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      seq_reg <= LMD_IDLE;
      beat_reg <= '0;
      byte_reg <= '0;
    end else begin
      case (seq_reg)
        LMD_IDLE: begin
          if (fetch_valid) begin
            byte_reg <= fetch_data;
            beat_reg <= beats_needed;
            if (beats_needed != '0) begin
              seq_reg <= LMD_SEND;
            end
          end
        end
        LMD_SEND: begin
          beat_reg <= beat_reg - 2'h1;
          if (beat_reg == BEATS_ONE) begin
            seq_reg <= LMD_IDLE;
          end
        end
        default: seq_reg <= LMD_IDLE;
      endcase
    end
  end

  // Panel lanes: dual and 8-bit split the byte, single 4-bit sends high then low.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      up_reg <= '0;
      down_reg <= '0;
      strobe_reg <= 1'b0;
    end else begin
      strobe_reg <= 1'b0;
      if (seq_reg == LMD_IDLE && fetch_valid) begin
        strobe_reg <= 1'b1;
        up_reg <= fetch_data[7:4];
        down_reg <= (is_dual || is_bus8) ? fetch_data[3:0] : 4'h0;
      end else if (seq_reg == LMD_SEND) begin
        strobe_reg <= 1'b1;
        if (is_dual || is_bus8) begin
          up_reg <= byte_reg[7:4];
          down_reg <= byte_reg[3:0];
        end else begin
          // The first beat already sent the high nibble, so odd counts carry the low one.
          up_reg <= beat_reg[0] ? byte_reg[3:0] : byte_reg[7:4];
          down_reg <= 4'h0;
        end
      end
    end
  end
  assign up_data = up_reg;
  assign down_data = down_reg;
  assign panel_strobe = strobe_reg;

  // Checks on register access, mode decode and the panel sequencer.
  AST_INVALID_WRITE: assert property (@(posedge core_clk) disable iff (rst)
    (wr_edge && index_data_select && !idx_valid) |=> $stable(regs_reg[SLOT_MODE]))
    else $error("Invalid write changed the mode register.");
  AST_INVALID_READ: assert property (@(posedge core_clk) disable iff (rst)
    (!cs_n && !rd_n && index_data_select && !idx_valid) |=> (db_out == '0))
    else $error("Invalid read returned nonzero data.");
  AST_INDEX_LOAD: assert property (@(posedge core_clk) disable iff (rst)
    (wr_edge && !index_data_select) |=> (index_reg == $past(db_in[IDX_W-1:0])))
    else $error("Index register did not load.");
  AST_HTOTAL_RW: assert property (@(posedge core_clk) disable iff (rst)
    (wr_edge && index_data_select && index_reg == IDX_HTOTAL)
    |=> (regs_reg[SLOT_HTOTAL] == $past(db_in)))
    else $error("Horizontal total did not store the written value.");
  AST_MODE_HOLD: assert property (@(posedge core_clk) disable iff (rst)
    !frame_start |=> $stable(mode_reg))
    else $error("Mode changed outside a frame boundary.");
  AST_BAD_COMBO: assert property (@(posedge core_clk) disable iff (rst)
    (frame_start && decoded == MODE_NONE) |=> (mode_error && $stable(mode_reg)))
    else $error("Prohibited combination not held off.");
  AST_LARGE: assert property (@(posedge core_clk) disable iff (rst)
    (mode_num == MODE_13) |-> (dual_panel && graphic_mode && mem_rate_mbps == RATE_LARGE))
    else $error("Large screen mode has wrong attributes.");
  AST_WIDE_CHAR: assert property (@(posedge core_clk) disable iff (rst)
    wide_mode |-> (!graphic_mode && mem_rate_mbps == RATE_WIDE))
    else $error("Wide mode outside character display.");
  AST_WIDE_TWICE: assert property (@(posedge core_clk) disable iff (rst)
    (fetch_ready && fetch_valid && wide_mode && (dual_panel || bus8_mode))
    |=> panel_strobe ##1 (panel_strobe && up_data == $past(up_data)))
    else $error("Wide character not sent twice.");
  AST_WIDE_OR: assert property (@(posedge core_clk) disable iff (rst)
    (frame_start && regs_reg[SLOT_MODE][MBIT_WIDE] && $past(regs_reg[SLOT_MODE][MBIT_WIDE])
     && !graphic_char_sel && decoded != MODE_NONE) |=> wide_mode)
    else $error("Mode bit 2 did not select wide display.");
  COV_MODE13: cover property (@(posedge core_clk) disable iff (rst) mode_num == MODE_13);
  COV_WIDE_FETCH: cover property (@(posedge core_clk) disable iff (rst)
    fetch_valid && fetch_ready && wide_mode);
  COV_BAD: cover property (@(posedge core_clk) disable iff (rst) mode_error);
  COV_INVALID_WR: cover property (@(posedge core_clk) disable iff (rst)
    wr_edge && index_data_select && !idx_valid);
endmodule : lmd_top

// ### verification/lmd_host.sv
// Host processor model that drives the register bus of the mode decode block.
`timescale 1ns/100ps
module lmd_host (
  input wire logic core_clk,
  output logic cs_n,
  output logic wr_n,
  output logic rd_n,
  output logic index_data_select,
  output logic [lmd_pkg::DATA_W-1:0] db_in,
  input wire logic [lmd_pkg::DATA_W-1:0] db_out
);
  import lmd_pkg::*;

  // The bus starts idle; data lines never rest on a value the device could mistake.
  initial begin
    cs_n = 1'b1;
    wr_n = 1'b1;
    rd_n = 1'b1;
    index_data_select = 1'b0;
    db_in = 8'h00;
  end

  // One write: strobes held across one rising edge, then released so wr_n rises between writes.
  task automatic bus_write(input logic rs, input logic [DATA_W-1:0] data);
    @(negedge core_clk);
    index_data_select = rs;
    db_in = data;
    cs_n = 1'b0;
    wr_n = 1'b0;
    @(negedge core_clk);
    cs_n = 1'b1;
    wr_n = 1'b1;
    db_in = ~data;
  endtask : bus_write

  // One read: strobe held until the registered answer has landed.
  task automatic bus_read(input logic rs, output logic [DATA_W-1:0] data);
    @(negedge core_clk);
    index_data_select = rs;
    cs_n = 1'b0;
    rd_n = 1'b0;
    repeat (2) @(negedge core_clk);
    data = db_out;
    cs_n = 1'b1;
    rd_n = 1'b1;
  endtask : bus_read

  // Programs the displayed and total counts so the line restriction holds exactly.
  task automatic set_format(input int m, input logic [DATA_W-1:0] nhd);
    bus_write(1'b0, {3'h0, IDX_HDISP});
    bus_write(1'b1, nhd);
    bus_write(1'b0, {3'h0, IDX_HTOTAL});
    bus_write(1'b1, nhd + 8'(16 / m) - 8'h01);
  endtask : set_format
endmodule : lmd_host

// ### verification/lmd_top_tb.sv
// Self-checking testbench for the LCD mode decode and register select block.
`timescale 1ns/100ps
module lmd_top_tb;
  import lmd_pkg::*;
  logic core_clk, rst, cs_n, wr_n, rd_n, index_data_select, db_oe;
  logic [7:0] db_in, db_out, fetch_data, rd;
  logic screen_split_sel, graphic_char_sel, bus_width_sel, wide_sel, attr_func_sel;
  logic frame_start, fetch_valid, fetch_ready, panel_strobe, mode_error, fmt_violation;
  logic [3:0] up_data, down_data, mode_num;
  logic dual_panel, bus8_mode, graphic_mode, wide_mode, attr_enable, or_enable;
  logic [5:0] mem_rate_mbps;
  int errors = 0;
  int total_checks = 0;
  // Legal pin sets (split, graphic, width, wide, attribute) and their modes.
  logic [4:0] comb_tab [19] = '{5'h10, 5'h11, 5'h12, 5'h13, 5'h19, 5'h18, 5'h00, 5'h01,
    5'h02, 5'h03, 5'h09, 5'h08, 5'h04, 5'h05, 5'h06, 5'h07, 5'h0D, 5'h0C, 5'h1D};
  logic [3:0] mode_tab [19] = '{4'h1, 4'h1, 4'h2, 4'h2, 4'h3, 4'h4, 4'h5, 4'h5, 4'h6,
    4'h6, 4'h7, 4'h8, 4'h9, 4'h9, 4'hA, 4'hA, 4'hB, 4'hC, 4'hD};

  lmd_top lmd_top_i (.core_clk, .rst, .cs_n, .wr_n, .rd_n, .index_data_select, .db_in,
    .db_out, .db_oe, .screen_split_sel, .graphic_char_sel, .bus_width_sel, .wide_sel,
    .attr_func_sel, .frame_start, .fetch_valid, .fetch_data, .fetch_ready, .up_data,
    .down_data, .panel_strobe, .mode_num, .mode_error, .dual_panel, .bus8_mode,
    .graphic_mode, .wide_mode, .attr_enable, .or_enable, .mem_rate_mbps, .fmt_violation);
  lmd_host lmd_host_i (.core_clk, .cs_n, .wr_n, .rd_n, .index_data_select, .db_in, .db_out);

  // Character clock at 25 MHz.
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic summarize();
    $display("Checks %0d, mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : summarize

  // Board pins change, then a frame boundary applies them.
  task automatic apply_mode(input logic [4:0] p);
    @(negedge core_clk);
    {screen_split_sel, graphic_char_sel, bus_width_sel, wide_sel, attr_func_sel} = p;
    @(negedge core_clk);
    frame_start = 1'b1;
    @(negedge core_clk);
    frame_start = 1'b0;
    @(negedge core_clk);
  endtask : apply_mode

  task automatic check_mode(input logic [3:0] m, input logic at);
    logic g, w;
    g = m inside {3, 4, 7, 8, 11, 12, 13};
    w = m inside {2, 6, 10};
    check("mode_num", {4'h0, m}, {4'h0, mode_num});
    check("dual_panel", {7'h0, m inside {1, 2, 3, 4, 13}}, {7'h0, dual_panel});
    check("bus8_mode", {7'h0, m inside {9, 10, 11, 12}}, {7'h0, bus8_mode});
    check("graphic_mode", {7'h0, g}, {7'h0, graphic_mode});
    check("wide_mode", {7'h0, w}, {7'h0, wide_mode});
    check("attr_enable", {7'h0, !g && at}, {7'h0, attr_enable});
    check("or_enable", {7'h0, !g && !at}, {7'h0, or_enable});
    check("mem_rate", {2'h0, w ? RATE_WIDE : (m == 4'hD ? RATE_LARGE : RATE_NORMAL)},
      {2'h0, mem_rate_mbps});
  endtask : check_mode

  task automatic test_reset();
    check("mode_num", 8'h05, {4'h0, mode_num});
    check("mode_error", 8'h00, {7'h0, mode_error});
    check("db_oe", 8'h00, {7'h0, db_oe});
    // The read strobe is low from the first falling edge, so the enable must stand at the second.
    fork
      lmd_host_i.bus_read(1'b1, rd);
      begin
        repeat (2) @(negedge core_clk);
        check("db_oe", 8'h01, {7'h0, db_oe});
      end
    join
    check("horiz_total_reg", 8'h00, rd);
    $display("Test reset finished");
  endtask : test_reset

  task automatic test_regs();
    logic [4:0] good [6] = '{5'h00, 5'h01, 5'h09, 5'h0F, 5'h12, 5'h15};
    logic [4:0] bad [6] = '{5'h02, 5'h08, 5'h10, 5'h11, 5'h17, 5'h1F};
    foreach (good[i]) begin
      lmd_host_i.bus_write(1'b0, {3'h0, good[i]});
      lmd_host_i.bus_write(1'b1, 8'hA0 + 8'(i));
      lmd_host_i.bus_read(1'b0, rd);
      check("index_reg", {3'h0, good[i]}, rd);
    end
    foreach (bad[i]) begin
      lmd_host_i.bus_write(1'b0, {3'h0, bad[i]});
      lmd_host_i.bus_write(1'b1, 8'h5A);
      lmd_host_i.bus_read(1'b1, rd);
      check("invalid read", 8'h00, rd);
    end
    foreach (good[i]) begin
      lmd_host_i.bus_write(1'b0, {3'h0, good[i]});
      lmd_host_i.bus_read(1'b1, rd);
      check("data register", 8'hA0 + 8'(i), rd);
    end
    $display("Test registers finished");
  endtask : test_regs

  task automatic test_modes();
    foreach (comb_tab[i]) begin
      apply_mode(comb_tab[i]);
      check_mode(mode_tab[i], comb_tab[i][0]);
      check("mode_error", 8'h00, {7'h0, mode_error});
    end
    apply_mode(5'h1A);
    check("held mode", 8'h0D, {4'h0, mode_num});
    check("mode_error", 8'h01, {7'h0, mode_error});
    apply_mode(5'h14);
    check("mode_error", 8'h01, {7'h0, mode_error});
    apply_mode(5'h04);
    check_mode(4'h9, 1'b0);
    check("mode_error", 8'h00, {7'h0, mode_error});
    $display("Test modes finished");
  endtask : test_modes

  task automatic test_regbits();
    logic [7:0] val [5] = '{8'h04, 8'h01, 8'h08, 8'h09, 8'h00};
    logic [3:0] exp [5] = '{4'h6, 4'h5, 4'h8, 4'h7, 4'h5};
    lmd_host_i.bus_write(1'b0, {3'h0, IDX_MODE});
    foreach (val[i]) begin
      lmd_host_i.bus_write(1'b1, val[i]);
      apply_mode(5'h00);
      check_mode(exp[i], val[i][0]);
    end
    $display("Test mode register finished");
  endtask : test_regbits

  task automatic send_byte(input logic [4:0] p, input logic [7:0] d, input int n);
    int seen;
    logic sgl;
    seen = 0;
    sgl = !p[4] && !p[2];
    apply_mode(p);
    fetch_data = d;
    fetch_valid = 1'b1;
    @(negedge core_clk);
    fetch_valid = 1'b0;
    fetch_data = ~d;
    if (n > 1) check("fetch_ready", 8'h00, {7'h0, fetch_ready});
    repeat (8) begin
      if (panel_strobe === 1'b1) begin
        check("up_data", {4'h0, (sgl && seen[0]) ? d[3:0] : d[7:4]}, {4'h0, up_data});
        check("down_data", {4'h0, sgl ? 4'h0 : d[3:0]}, {4'h0, down_data});
        seen++;
      end
      @(negedge core_clk);
    end
    check("beats", 8'(n), 8'(seen));
    check("fetch_ready", 8'h01, {7'h0, fetch_ready});
  endtask : send_byte

  task automatic test_panel();
    send_byte(5'h10, 8'hA5, 1);
    send_byte(5'h12, 8'hA5, 2);
    send_byte(5'h00, 8'hA5, 2);
    send_byte(5'h02, 8'h3C, 4);
    send_byte(5'h04, 8'h3C, 1);
    send_byte(5'h06, 8'h3C, 2);
    $display("Test panel finished");
  endtask : test_panel

  task automatic test_format();
    logic [4:0] p [3] = '{5'h00, 5'h12, 5'h10};
    int m [3] = '{1, 4, 2};
    foreach (p[i]) begin
      apply_mode(p[i]);
      lmd_host_i.set_format(m[i], 8'h20);
      check("fmt_violation", 8'h00, {7'h0, fmt_violation});
      lmd_host_i.bus_write(1'b1, 8'h20 + 8'(16 / m[i]) - 8'h02);
      check("fmt_violation", 8'h01, {7'h0, fmt_violation});
    end
    $display("Test format finished");
  endtask : test_format

  // Reset, then the scenarios in turn.
  initial begin
    rst = 1'b1;
    {screen_split_sel, graphic_char_sel, bus_width_sel, wide_sel, attr_func_sel} = 5'h00;
    frame_start = 1'b0;
    fetch_valid = 1'b0;
    fetch_data = 8'h00;
    repeat (5) @(negedge core_clk);
    rst = 1'b0;
    test_reset();
    test_regs();
    test_modes();
    test_regbits();
    test_panel();
    test_format();
    summarize();
  end

  // Watchdog far beyond the few hundred cycles the scenarios need.
  initial begin
    #(20000 * 40);
    errors++;
    summarize();
  end
endmodule : lmd_top_tb
